/* File: pkg/ssm_map.svh */
// Register offsets, field positions, reset values and timing figures of the status bank.
// Assumes it is included by its bare name wherever these values are needed.
`ifndef SSM_MAP_SVH
`define SSM_MAP_SVH
`define SSM_ADDR_W 8
`define SSM_OFS_PWR_LOSS 8'h00
`define SSM_OFS_SPARE 8'h04
`define SSM_OFS_ERR 8'h08
`define SSM_OFS_MAX_CYC 8'h0c
`define SSM_OFS_CUR_CYC 8'h10
`define SSM_OFS_CTRL 8'h14
`define SSM_OFS_LIMIT 8'h18
`define SSM_OFS_ERR_CLR 8'h1c
`define SSM_BIT_SETUP_PWR 0
`define SSM_BIT_SETUP_START 1
`define SSM_BIT_SETUP_RUN 2
`define SSM_BIT_LONG_CYC 5
`define SSM_BIT_PROG_FULL 6
`define SSM_BIT_UNSUP_INSTR 7
`define SSM_BIT_BAD_AREA 8
`define SSM_BIT_FLASH 9
`define SSM_BIT_RODATA 10
`define SSM_BIT_SETUP_CSUM 11
`define SSM_BIT_PROG_ERR 12
`define SSM_BIT_UNUSED 13
`define SSM_BIT_SAVE_ERR 14
`define SSM_ERR_IMPL_MASK 16'h5fe7
`define SSM_WORD_RESET 16'h0000
`define SSM_BCD_MAX 16'h9999
`define SSM_BCD_ONE 16'h0001
`define SSM_CTRL_UNIT_LSB 0
`define SSM_CLK_PERIOD_NS 8
`define SSM_BASE_UNIT_NS 100000
`define SSM_DIV_BASE 7'h01
`define SSM_DIV_1MS 7'h0a
`define SSM_DIV_10MS 7'h64
`endif

/* File: pkg/ssm_pkg.sv */
// Types shared by the status bank.
// Assumes the map header supplies all numeric values except the enum codes set here.
package ssm_pkg;
	typedef enum logic [1:0] {
		SSM_UNIT_DEFAULT = 2'h0,
		SSM_UNIT_10MS = 2'h1,
		SSM_UNIT_100MS = 2'h2,
		SSM_UNIT_1S = 2'h3
	} ssm_unit_type;
	typedef enum logic [1:0] {
		SSM_STOPPED = 2'b01,
		SSM_RUNNING = 2'b10
	} ssm_mode_type;
endpackage : ssm_pkg

/* File: hdl/ssm_status_bank.sv */
// Status word bank of a small controller: power loss count, self-check error flags and scan cycle times.
// Assumes one clock, event inputs that are one-cycle pulses synchronous to sys_clk, and a simple
// strobe register port whose read data appear one cycle after the read strobe.
//
// Decided for this implementation: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
`include "ssm_map.svh"
//
// Behaviour
// R01 - Power-up setup fault found at power-on sets error bit 00.
// R02 - Start-up setup fault found at operation start sets error bit 01.
// R03 - Fault in continuously read setup words sets error bit 02.
// R04 - Scan cycle longer than configured limit sets error bit 05.
// R05 - Program storage full sets error bit 06.
// R06 - Unsupported instructions in program set error bit 07.
// R07 - Operand address in no existing data area sets error bit 08.
// R08 - Flash memory fault sets error bit 09.
// R09 - Read-only data checksum mismatch sets bit 10 and requests region initialise.
// R10 - Setup parameter area checksum mismatch sets error bit 11.
// R11 - Program checksum mismatch or improper instruction sets error bit 12.
// R12 - Unused error bit 13 is forced to zero at every power-on.
// R13 - Retained data lost across power loss sets bit 14 at power-on.
// R14 - Lost retained data requests clearing of retained areas and stopped mode.
// R15 - Longest scan cycle since start kept as four BCD digits.
// R16 - Longest cycle cleared at operation start, kept at operation stop.
// R17 - Cycle unit from setup selection: 0.1 ms, 0.1 ms, 1 ms, 10 ms.
// R18 - Latest scan cycle stored in BCD, retained after operation stops.
// R19 - Status words keep contents across power loss and run/stop changes.
// R20 - Cycle measured scan start to scan start, counted in BCD units.
module ssm_status_bank #(
	parameter int BASE_TICK_CYCLES = `SSM_BASE_UNIT_NS / `SSM_CLK_PERIOD_NS
) (
	input logic sys_clk,
	input logic rst,
	input logic [`SSM_ADDR_W-1:0] reg_addr,
	input logic [31:0] reg_wdata,
	input logic reg_wr,
	input logic reg_rd,
	output logic [31:0] reg_rdata,
	input logic power_on,
	input logic run_start,
	input logic run_stop,
	input logic scan_start,
	input logic setup_power_up_err,
	input logic setup_start_up_err,
	input logic setup_run_err,
	input logic program_full,
	input logic unsupported_instr,
	input logic bad_area_address,
	input logic flash_fault,
	input logic rodata_csum_err,
	input logic setup_csum_err,
	input logic program_csum_err,
	input logic improper_instr,
	input logic retained_lost,
	output logic rodata_init_req,
	output logic retained_clear_req,
	output logic force_program_mode,
	output logic running
);

	localparam int TICK_W = $clog2(BASE_TICK_CYCLES + 1);

	// Adds one to a four-digit BCD word, holding at the top instead of wrapping.
	function automatic logic [15:0] bcd_inc(input logic [15:0] v);
		logic [15:0] r;
		logic carry;
		r = v;
		carry = 1'b1;
		if (v == `SSM_BCD_MAX) begin
			carry = 1'b0;
		end
		for (int i = 0; i < 4; i++) begin
			if (carry) begin
				if (r[i*4 +: 4] == 4'h9) begin
					r[i*4 +: 4] = 4'h0;
				end else begin
					r[i*4 +: 4] = r[i*4 +: 4] + 4'h1;
					carry = 1'b0;
				end
			end
		end
		return r;
	endfunction : bcd_inc

	// Number of base ticks that make up one stored cycle unit.
	function automatic logic [6:0] unit_div(input ssm_pkg::ssm_unit_type u);
		logic [6:0] d;
		d = `SSM_DIV_BASE;
		unique case (u)
			ssm_pkg::SSM_UNIT_DEFAULT: d = `SSM_DIV_BASE;
			ssm_pkg::SSM_UNIT_10MS: d = `SSM_DIV_BASE;
			ssm_pkg::SSM_UNIT_100MS: d = `SSM_DIV_1MS;
			ssm_pkg::SSM_UNIT_1S: d = `SSM_DIV_10MS;
		endcase
		return d;
	endfunction : unit_div

	// Decodes a register write to one offset; every writable word goes through it.
	function automatic logic wr_hit(input logic wr, input logic [`SSM_ADDR_W-1:0] addr,
		input logic [`SSM_ADDR_W-1:0] ofs);
		return wr && (addr == ofs);
	endfunction : wr_hit

	// Four-digit BCD words order like their binary patterns, so a plain compare finds the longer one.
	function automatic logic bcd_longer(input logic [15:0] a, input logic [15:0] b);
		return a > b;
	endfunction : bcd_longer

	ssm_pkg::ssm_mode_type mode_q;
	ssm_pkg::ssm_unit_type unit_q;
	logic [15:0] limit_q;
	logic [15:0] pwr_loss_q;
	logic [15:0] err_q;
	logic [15:0] err_d;
	logic [15:0] err_set;
	logic [15:0] err_clr;
	logic [15:0] max_cyc_q;
	logic [15:0] cur_cyc_q;
	logic [15:0] cyc_cnt_q;
	logic meas_valid_q;
	logic [TICK_W-1:0] tick_cnt_q;
	logic [6:0] unit_cnt_q;
	logic tick_en;
	logic unit_en;
	logic cycle_done;
	logic long_cycle;
	logic lost_event;
	logic [31:0] rdata_q;
	logic rodata_init_q;
	logic retained_clear_q;
	logic force_prog_q;
	logic [31:0] rd_word;

	assign running = (mode_q == ssm_pkg::SSM_RUNNING);
	assign cycle_done = scan_start && running && meas_valid_q;
	// A zero limit means no limit has been set, so the long cycle check stays quiet.
	assign long_cycle = cycle_done && (limit_q != `SSM_WORD_RESET) && bcd_longer(cyc_cnt_q, limit_q); // [R04]
	// Power returning without its retained data overrides every mode request.
	assign lost_event = power_on && retained_lost;

	// Both unused one-hot codes fall back to stopped, the state in which nothing is measured.
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			mode_q <= ssm_pkg::SSM_STOPPED;
		end else if (lost_event) begin
			mode_q <= ssm_pkg::SSM_STOPPED; // [R14]
		end else begin
			unique case (mode_q)
				ssm_pkg::SSM_STOPPED: begin
					if (run_start) begin
						mode_q <= ssm_pkg::SSM_RUNNING;
					end
				end
				ssm_pkg::SSM_RUNNING: begin
					if (run_stop && !run_start) begin
						mode_q <= ssm_pkg::SSM_STOPPED;
					end
				end
				default: begin
					mode_q <= ssm_pkg::SSM_STOPPED;
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			unit_q <= ssm_pkg::SSM_UNIT_DEFAULT;
		end else if (wr_hit(reg_wr, reg_addr, `SSM_OFS_CTRL)) begin
			unit_q <= ssm_pkg::ssm_unit_type'(reg_wdata[`SSM_CTRL_UNIT_LSB +: 2]); // [R17]
		end
	end

	// A limit written in mid-cycle already applies to the cycle then running.
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			limit_q <= `SSM_WORD_RESET;
		end else if (wr_hit(reg_wr, reg_addr, `SSM_OFS_LIMIT)) begin
			limit_q <= reg_wdata[15:0]; // [R04]
		end
	end

	// Base tick and unit enable restart at every scan start, so each cycle counts from a clean phase.
	assign tick_en = (tick_cnt_q == TICK_W'(BASE_TICK_CYCLES - 1));
	// At least rather than equal, so a unit change in mid-cycle cannot stall the count for a wrap.
	assign unit_en = tick_en && (unit_cnt_q >= unit_div(unit_q) - 7'h01); // [R17]

	always_ff @(posedge sys_clk) begin
		if (rst || scan_start || tick_en) begin
			tick_cnt_q <= '0;
		end else begin
			tick_cnt_q <= tick_cnt_q + TICK_W'(1);
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst || scan_start || unit_en) begin
			unit_cnt_q <= '0;
		end else if (tick_en) begin
			unit_cnt_q <= unit_cnt_q + 7'h01;
		end
	end

	// The cycle counter is kept in BCD directly, which avoids a binary to BCD converter.
	always_ff @(posedge sys_clk) begin
		if (rst || scan_start) begin
			cyc_cnt_q <= `SSM_WORD_RESET; // [R20]
		end else if (unit_en) begin
			cyc_cnt_q <= bcd_inc(cyc_cnt_q); // [R20]
		end
	end

	// The first scan after a start has no earlier scan to measure from, so it only arms the count.
	always_ff @(posedge sys_clk) begin
		if (rst || run_start || !running) begin
			meas_valid_q <= 1'b0;
		end else if (scan_start) begin
			meas_valid_q <= 1'b1; // [R20]
		end
	end

	// BCD words order the same way as their binary patterns, so a plain compare finds the longer one.
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			max_cyc_q <= `SSM_WORD_RESET;
		end else if (run_start) begin
			max_cyc_q <= `SSM_WORD_RESET; // [R16]
		end else if (cycle_done && bcd_longer(cyc_cnt_q, max_cyc_q)) begin
			max_cyc_q <= cyc_cnt_q; // [R15]
		end
	end

	// Only a finished cycle updates this word; stopping and power loss leave it untouched.
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			cur_cyc_q <= `SSM_WORD_RESET;
		end else if (cycle_done) begin
			cur_cyc_q <= cyc_cnt_q; // [R18] [R19]
		end
	end

	// The count holds at its top value, so a long history never reads as only a few losses.
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			pwr_loss_q <= `SSM_WORD_RESET;
		end else if (power_on) begin
			pwr_loss_q <= bcd_inc(pwr_loss_q); // [R19]
		end
	end

	// Level causes set their flag in every cycle they stand, so a clear only sticks once they are gone.
	always_comb begin
		err_set = '0;
		err_set[`SSM_BIT_SETUP_PWR] = power_on && setup_power_up_err; // [R01]
		err_set[`SSM_BIT_SETUP_START] = run_start && setup_start_up_err; // [R02]
		err_set[`SSM_BIT_SETUP_RUN] = setup_run_err; // [R03]
		err_set[`SSM_BIT_LONG_CYC] = long_cycle; // [R04]
		err_set[`SSM_BIT_PROG_FULL] = program_full; // [R05]
		err_set[`SSM_BIT_UNSUP_INSTR] = unsupported_instr; // [R06]
		err_set[`SSM_BIT_BAD_AREA] = bad_area_address; // [R07]
		err_set[`SSM_BIT_FLASH] = flash_fault; // [R08]
		err_set[`SSM_BIT_RODATA] = rodata_csum_err; // [R09]
		err_set[`SSM_BIT_SETUP_CSUM] = setup_csum_err; // [R10]
		err_set[`SSM_BIT_PROG_ERR] = program_csum_err || improper_instr; // [R11]
		err_set[`SSM_BIT_SAVE_ERR] = lost_event; // [R13]
	end

	always_comb begin
		err_clr = '0;
		if (wr_hit(reg_wr, reg_addr, `SSM_OFS_ERR_CLR)) begin
			err_clr = reg_wdata[15:0];
		end
		// A flag raised in the same cycle as its clear survives.
		err_d = ((err_q & ~err_clr) | err_set) & `SSM_ERR_IMPL_MASK;
		if (power_on) begin
			err_d[`SSM_BIT_UNUSED] = 1'b0; // [R12]
		end
	end

	// Flags live until software clears them or a cold reset; a power loss alone leaves them alone.
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			err_q <= `SSM_WORD_RESET;
		end else begin
			err_q <= err_d; // [R19]
		end
	end

	// The request pulses are kept apart so that each can be retimed on its own.
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			rodata_init_q <= 1'b0;
		end else begin
			rodata_init_q <= rodata_csum_err; // [R09]
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			retained_clear_q <= 1'b0;
		end else begin
			retained_clear_q <= lost_event; // [R14]
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			force_prog_q <= 1'b0;
		end else begin
			force_prog_q <= lost_event; // [R14]
		end
	end

	assign rodata_init_req = rodata_init_q;
	assign retained_clear_req = retained_clear_q;
	assign force_program_mode = force_prog_q;

	// Unmapped offsets read zero, so software probing the bank sees no stray bits.
	always_comb begin
		rd_word = '0;
		unique case (reg_addr)
			`SSM_OFS_PWR_LOSS: rd_word[15:0] = pwr_loss_q;
			`SSM_OFS_SPARE: rd_word[15:0] = `SSM_WORD_RESET;
			`SSM_OFS_ERR: rd_word[15:0] = err_q;
			`SSM_OFS_MAX_CYC: rd_word[15:0] = max_cyc_q;
			`SSM_OFS_CUR_CYC: rd_word[15:0] = cur_cyc_q;
			`SSM_OFS_CTRL: rd_word[1:0] = unit_q;
			`SSM_OFS_LIMIT: rd_word[15:0] = limit_q;
			default: rd_word = '0;
		endcase
	end

	// Read data stand for exactly the cycle after the strobe and read zero otherwise.
	always_ff @(posedge sys_clk) begin
		if (rst || !reg_rd) begin
			rdata_q <= '0;
		end else begin
			rdata_q <= rd_word;
		end
	end

	assign reg_rdata = rdata_q;

endmodule : ssm_status_bank

/* File: verification/ssm_status_bank_checker.sv */
// Checker of the status bank outputs, attached to the top module by bind.
// Assumes one clock domain and the map header on the include path.
`timescale 1ns/1ps
`include "ssm_map.svh"
module ssm_status_bank_checker #(
	parameter int BASE_TICK_CYCLES = 4
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic [`SSM_ADDR_W-1:0] reg_addr,
	input wire logic reg_rd,
	input wire logic [31:0] reg_rdata,
	input wire logic power_on,
	input wire logic run_start,
	input wire logic run_stop,
	input wire logic rodata_csum_err,
	input wire logic retained_lost,
	input wire logic rodata_init_req,
	input wire logic retained_clear_req,
	input wire logic force_program_mode,
	input wire logic running
);
	logic bcd_ok;
	logic lost;
	always_comb bcd_ok = reg_rdata[3:0] < 4'ha && reg_rdata[7:4] < 4'ha &&
		reg_rdata[11:8] < 4'ha && reg_rdata[15:12] < 4'ha;
	always_comb lost = power_on && retained_lost;
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (rst);
	chk_init_follow: assert property (rodata_init_req == $past(rodata_csum_err))
		else $error("init request does not follow checksum fault");
	chk_lost_clear: assert property (lost |=> retained_clear_req && force_program_mode && !running)
		else $error("lost data did not clear and stop");
	chk_no_clear: assert property (!lost |=> !retained_clear_req && !force_program_mode)
		else $error("clear request without lost data");
	chk_run_start: assert property (run_start && !lost |=> running)
		else $error("start did not enter running");
	chk_run_stop: assert property (run_stop && !run_start |=> !running)
		else $error("stop did not leave running");
	chk_mode_hold: assert property (!run_start && !run_stop && !lost |=> $stable(running))
		else $error("mode changed without an event");
	chk_spare_bits: assert property (reg_rd && reg_addr == `SSM_OFS_ERR |=>
		reg_rdata[15:0] == (reg_rdata[15:0] & `SSM_ERR_IMPL_MASK)) else $error("unused error bit set");
	chk_cycle_bcd: assert property (reg_rd && (reg_addr == `SSM_OFS_MAX_CYC || reg_addr == `SSM_OFS_CUR_CYC)
		|=> bcd_ok) else $error("cycle word is not decimal");
	cov_lost: cover property (lost);
	cov_stop: cover property (running && run_stop);
	cov_init: cover property (rodata_init_req);
endmodule : ssm_status_bank_checker
bind ssm_status_bank ssm_status_bank_checker #(.BASE_TICK_CYCLES(BASE_TICK_CYCLES)) ssm_status_bank_checker_inst (
	.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .power_on(power_on),
	.run_start(run_start), .run_stop(run_stop), .rodata_csum_err(rodata_csum_err), .retained_lost(retained_lost),
	.rodata_init_req(rodata_init_req), .retained_clear_req(retained_clear_req),
	.force_program_mode(force_program_mode), .running(running));

/* File: verification/tb_ssm_status_bank.sv */
// Testbench of the status bank: register reads compared with values worked out here.
// Assumes read data follow the read strobe by one cycle; event inputs are packed in ev.
`timescale 1ns/1ps
`include "ssm_map.svh"
module tb_ssm_status_bank;
	localparam int BT = 4;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [31:0] reg_rdata;
	logic [15:0] ev = 16'h0;
	logic rd_pend = 1'b0;
	logic [31:0] exp_q[$];
	int err_total = 0;
	int total_checks = 0;
	int cyc = 0;
	int k;
	int kmax = 0;
	int mul[4] = '{1, 1, 10, 100};
	int bitmap[9] = '{2, 6, 7, 8, 9, 10, 11, 12, 12};
	ssm_status_bank #(.BASE_TICK_CYCLES(BT)) ssm_status_bank_inst (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .power_on(ev[0]),
		.run_start(ev[1]), .run_stop(ev[2]), .scan_start(ev[3]), .setup_power_up_err(ev[4]),
		.setup_start_up_err(ev[5]), .setup_run_err(ev[6]), .program_full(ev[7]), .unsupported_instr(ev[8]),
		.bad_area_address(ev[9]), .flash_fault(ev[10]), .rodata_csum_err(ev[11]), .setup_csum_err(ev[12]),
		.program_csum_err(ev[13]), .improper_instr(ev[14]), .retained_lost(ev[15]), .rodata_init_req(),
		.retained_clear_req(), .force_program_mode(), .running());
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= {16'h0, d};
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [15:0] e);
		exp_q.push_back({16'h0, e});
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
	endtask : rd
	task automatic pulse(input logic [15:0] v);
		@(posedge sys_clk);
		ev <= v;
		@(posedge sys_clk);
		ev <= 16'h0;
	endtask : pulse
	// The two extra cycles of the scan pulse keep the span off a unit boundary.
	task automatic timed(input int n, input int m);
		repeat (BT * m * n) @(posedge sys_clk);
		pulse(16'h0008);
	endtask : timed
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("ERROR reg_rdata expected %h seen %h", exp, seen);
		end
	endtask : check
	task automatic report_and_stop();
		if (err_total == 0 && total_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : report_and_stop
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			err_total++;
			report_and_stop();
		end
		if (rd_pend) check(reg_rdata, exp_q.pop_front());
		rd_pend <= reg_rd;
	end
	initial begin
		forever #4 sys_clk = ~sys_clk;
	end
	initial begin
		void'($urandom(32'h77836b02));
		repeat (20) @(posedge sys_clk);
		rst <= 1'b0;
		wr(`SSM_OFS_PWR_LOSS, 16'h1234);
		for (int a = 0; a <= 32; a += 4) rd(8'(a), 16'h0);
		pulse(16'h8011);
		rd(`SSM_OFS_PWR_LOSS, 16'h0001);
		rd(`SSM_OFS_ERR, 16'h4001);
		for (int i = 0; i < 9; i++) begin
			wr(`SSM_OFS_ERR_CLR, 16'hffff);
			pulse(16'h0040 << i);
			rd(`SSM_OFS_ERR, 16'h0001 << bitmap[i]);
		end
		wr(`SSM_OFS_ERR_CLR, 16'hffff);
		pulse(16'h0001);
		rd(`SSM_OFS_ERR, 16'h0000);
		pulse(16'h0022);
		rd(`SSM_OFS_ERR, 16'h0002);
		// Short gaps between timed scans count at most one unit, so k starts at two.
		for (int u = 0; u < 4; u++) begin
			k = 2 + $urandom % 8;
			kmax = k > kmax ? k : kmax;
			wr(`SSM_OFS_CTRL, 16'(u));
			pulse(16'h0008);
			timed(k, mul[u]);
			rd(`SSM_OFS_CUR_CYC, 16'(k));
		end
		rd(`SSM_OFS_MAX_CYC, 16'(kmax));
		wr(`SSM_OFS_ERR_CLR, 16'hffff);
		wr(`SSM_OFS_CTRL, 16'h0002);
		wr(`SSM_OFS_LIMIT, 16'h0003);
		pulse(16'h0008);
		timed(3, 10);
		rd(`SSM_OFS_ERR, 16'h0000);
		timed(4, 10);
		rd(`SSM_OFS_ERR, 16'h0020);
		pulse(16'h0004);
		pulse(16'h0008);
		rd(`SSM_OFS_CUR_CYC, 16'h0004);
		rd(`SSM_OFS_MAX_CYC, 16'(kmax > 4 ? kmax : 4));
		pulse(16'h0002);
		rd(`SSM_OFS_MAX_CYC, 16'h0000);
		wr(`SSM_OFS_ERR_CLR, 16'hffff);
		pulse(16'h8001);
		rd(`SSM_OFS_ERR, 16'h4000);
		rd(`SSM_OFS_PWR_LOSS, 16'h0003);
		repeat (3) @(posedge sys_clk);
		report_and_stop();
	end
endmodule : tb_ssm_status_bank
